// ===== shared/kpi_pkg.sv
// constants for the keypad interrupt unit
package kpi_pkg;
  localparam int unsigned KPI_PINS            = 8;
  localparam logic [7:0]  KPI_ADDR_STATUS     = 8'h1A;
  localparam logic [7:0]  KPI_ADDR_ENABLE     = 8'h1B;
  localparam logic [7:0]  KPI_RESET_VALUE     = 8'h00;
  localparam int unsigned KPI_BIT_SENS        = 0;
  localparam int unsigned KPI_BIT_MASK        = 1;
  localparam int unsigned KPI_BIT_ACK         = 2;
  localparam int unsigned KPI_BIT_PEND        = 3;
  localparam int unsigned KPI_PIN_SIX         = 6;
  localparam logic [15:0] KPI_VECTOR_ADDR     = 16'hFFE0;
endpackage : kpi_pkg

// ===== hw/kpi_unit.sv
// keypad interrupt unit: eight-pin falling-edge / low-level request latch with registers
module kpi_unit #(
  parameter int unsigned PINS = kpi_pkg::KPI_PINS
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            rst,
  // register port
  input  wire logic [7:0]      addr,
  input  wire logic [7:0]      wdata,
  input  wire logic            wr_stb,
  input  wire logic            rd_stb,
  output logic      [7:0]      rdata,
  // port pins and port configuration
  input  wire logic [PINS-1:0] keypad_input_pin,
  input  wire logic [PINS-1:0] port_direction,
  input  wire logic [PINS-1:0] port_pullup_enable,
  input  wire logic            oscillator_select,
  input  wire logic            port_pin_six_enable,
  output logic      [PINS-1:0] pin_pullup_on,
  output logic      [PINS-1:0] pin_force_input,
  output logic      [PINS-1:0] pin_read_level,
  // cpu side
  input  wire logic            vector_fetch,
  output logic                 cpu_irq,
  output logic                 wake_request
);
  import kpi_pkg::*;

  logic [PINS-1:0] sync1_reg;
  logic [PINS-1:0] sync2_reg;
  logic [PINS-1:0] enable_reg;
  logic [PINS-1:0] enable_next;
  logic            sens_reg;
  logic            sens_next;
  logic            mask_reg;
  logic            mask_next;
  logic            latch_reg;
  logic            latch_next;
  // level mode remembers an acknowledge that came while a pin was still low
  logic            acked_reg;
  logic            acked_next;
  logic            any_low_reg;
  logic            any_low_next;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic [PINS-1:0] active_en;
  logic            any_low;
  logic            fall;
  logic            ack;
  logic            wr_status;
  logic            wr_enable;
  logic            rd_status;
  logic            rd_enable;

  // pin six is only a keypad input in the rc oscillator option
  function automatic logic [PINS-1:0] usable_mask(input logic osc, input logic six_en);
    logic [PINS-1:0] m;
    m = '1;
    if (PINS > KPI_PIN_SIX) begin
      m[KPI_PIN_SIX] = (osc == 1'b0) && six_en;
    end
    return m;
  endfunction

  // address match, shared by the write and the read decoders
  function automatic logic hits(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  // status image; the acknowledge bit and the upper nibble have no storage and read zero
  function automatic logic [7:0] status_word(input logic s, input logic m, input logic p);
    logic [7:0] w;
    w               = KPI_RESET_VALUE;
    w[KPI_BIT_SENS] = s;
    w[KPI_BIT_MASK] = m;
    w[KPI_BIT_PEND] = p;
    return w;
  endfunction

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= keypad_input_pin;
      sync2_reg <= sync1_reg;
    end
  end

  assign active_en       = enable_reg & usable_mask(oscillator_select, port_pin_six_enable);
  assign any_low         = |(active_en & ~sync2_reg);
  // only a change from all-high counts, so a second key under a held one is lost
  assign fall            = any_low && !any_low_reg;
  assign pin_pullup_on   = port_pullup_enable | active_en;
  assign pin_force_input = active_en;
  // a forced input still reads the output latch unless the direction bit is zero
  assign pin_read_level  = ~port_direction;
  assign wr_status       = wr_stb && hits(addr, KPI_ADDR_STATUS);
  assign wr_enable       = wr_stb && hits(addr, KPI_ADDR_ENABLE);
  assign rd_status       = rd_stb && hits(addr, KPI_ADDR_STATUS);
  assign rd_enable       = rd_stb && hits(addr, KPI_ADDR_ENABLE);
  assign ack             = (wr_status && wdata[KPI_BIT_ACK]) || vector_fetch;

  // software configuration
  always_comb begin
    enable_next = enable_reg;
    sens_next   = sens_reg;
    mask_next   = mask_reg;
    if (wr_enable) begin
      enable_next = wdata[PINS-1:0];
    end
    // a write carrying the acknowledge also rewrites mask and sensitivity
    if (wr_status) begin
      sens_next = wdata[KPI_BIT_SENS];
      mask_next = wdata[KPI_BIT_MASK];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_reg <= '0;
      sens_reg   <= 1'b0;
      mask_reg   <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      sens_reg   <= sens_next;
      mask_reg   <= mask_next;
    end
  end

  // request latch; later steps override earlier ones, so a set beats a clear
  always_comb begin
    latch_next   = latch_reg;
    acked_next   = acked_reg;
    any_low_next = any_low;
    if (!sens_reg) begin
      if (ack) begin
        latch_next = 1'b0;
      end
    end else begin
      if (ack && latch_reg) begin
        acked_next = 1'b1;
      end
      // acknowledge and all-high may arrive in either order
      if (!any_low && (ack || acked_reg)) begin
        latch_next = 1'b0;
      end
      // a low level keeps asking for as long as it lasts
      if (any_low) begin
        latch_next = 1'b1;
      end
    end
    if (fall) begin
      latch_next = 1'b1;
      acked_next = 1'b0;
    end
    if (!latch_next || !sens_reg) begin
      acked_next = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_reg   <= 1'b0;
      acked_reg   <= 1'b0;
      any_low_reg <= 1'b0;
    end else begin
      latch_reg   <= latch_next;
      acked_reg   <= acked_next;
      any_low_reg <= any_low_next;
    end
  end

  // read data stand for the one cycle after the strobe and are zero otherwise
  always_comb begin
    rdata_next = KPI_RESET_VALUE;
    if (rd_status) begin
      rdata_next = status_word(sens_reg, mask_reg, latch_reg);
    end
    if (rd_enable) begin
      rdata_next[PINS-1:0] = enable_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= KPI_RESET_VALUE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata        = rdata_reg;
  assign cpu_irq      = latch_reg && !mask_reg;
  // no clock gating here, so wait and stop do not stop the latch
  assign wake_request = cpu_irq;

  sequence s_fall;
    any_low && !any_low_reg;
  endsequence

  sequence s_edge_ack;
    !sens_reg && ack && !fall;
  endsequence

  sequence s_level_ack_low;
    sens_reg && latch_reg && any_low && ack && !fall;
  endsequence

  sequence s_level_acked_high;
    sens_reg && acked_reg && !any_low;
  endsequence

  sequence s_level_high_ack;
    sens_reg && latch_reg && !any_low && ack;
  endsequence

  sequence s_quiet;
    !fall && !latch_reg && !(sens_reg && any_low);
  endsequence

  AST_FALL_LATCHES: assert property (@(posedge clock) disable iff (rst)
    s_fall |=> latch_reg)
    else $error("falling input did not latch request");
  AST_EDGE_NO_RELATCH: assert property (@(posedge clock) disable iff (rst)
    (!sens_reg && any_low_reg && ack && !vector_fetch) |=> !latch_reg)
    else $error("edge mode latched while input already low");
  AST_LEVEL_HOLDS: assert property (@(posedge clock) disable iff (rst)
    (sens_reg && latch_reg && any_low && !wr_status) |=> latch_reg)
    else $error("level mode request dropped while input low");
  AST_ACK_CLEARS: assert property (@(posedge clock) disable iff (rst)
    (!sens_reg && ack && !(any_low && !any_low_reg)) |=> !latch_reg)
    else $error("acknowledge did not clear request");
  AST_ACK_READS_ZERO: assert property (@(posedge clock) disable iff (rst)
    rd_stb |=> !rdata[KPI_BIT_ACK])
    else $error("acknowledge bit read as one");
  AST_MASK_BLOCKS: assert property (@(posedge clock) disable iff (rst)
    mask_reg |-> !cpu_irq)
    else $error("masked request reached cpu");
  AST_PEND_READ: assert property (@(posedge clock) disable iff (rst)
    (rd_stb && addr == KPI_ADDR_STATUS) |=> rdata[KPI_BIT_PEND] == $past(latch_reg))
    else $error("pending flag read wrong");
  AST_SIX_GATED: assert property (@(posedge clock) disable iff (rst)
    oscillator_select |-> !active_en[KPI_PIN_SIX])
    else $error("input six active without rc option");
  AST_PULLUP: assert property (@(posedge clock) disable iff (rst)
    (pin_pullup_on & active_en) == active_en)
    else $error("enabled pin without pull-up");

  AST_LEVEL_ACK_KEPT: assert property (@(posedge clock) disable iff (rst)
    s_level_ack_low |=> (acked_reg && latch_reg))
    else $error("level mode acknowledge while low lost or cleared request");
  AST_LEVEL_RELEASE: assert property (@(posedge clock) disable iff (rst)
    s_level_acked_high |=> !latch_reg)
    else $error("level mode request kept after ack and release");
  AST_LEVEL_HIGH_ACK: assert property (@(posedge clock) disable iff (rst)
    s_level_high_ack |=> !latch_reg)
    else $error("level mode ack after release did not clear");
  AST_LEVEL_LOW_ASKS: assert property (@(posedge clock) disable iff (rst)
    (sens_reg && any_low) |=> latch_reg)
    else $error("level mode low input without request");
  AST_NO_SPURIOUS: assert property (@(posedge clock) disable iff (rst)
    s_quiet |=> !latch_reg)
    else $error("request latched without a cause");
  AST_FETCH_CLEARS: assert property (@(posedge clock) disable iff (rst)
    (!sens_reg && vector_fetch && !fall) |=> !latch_reg)
    else $error("vector fetch did not clear request");
  AST_IRQ_UNMASKED: assert property (@(posedge clock) disable iff (rst)
    (latch_reg && !mask_reg) |-> cpu_irq)
    else $error("unmasked request not offered to cpu");
  AST_WAKE: assert property (@(posedge clock) disable iff (rst)
    wake_request == cpu_irq)
    else $error("wake request differs from cpu request");
  AST_FORCE_INPUT: assert property (@(posedge clock) disable iff (rst)
    pin_force_input == active_en)
    else $error("enabled pin not forced to input");
  AST_READ_LEVEL: assert property (@(posedge clock) disable iff (rst)
    pin_read_level == ~port_direction)
    else $error("pin level readable with direction one");
  AST_IDLE_RDATA: assert property (@(posedge clock) disable iff (rst)
    !rd_stb |=> rdata == KPI_RESET_VALUE)
    else $error("read data present without read");
  AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (rst)
    wr_enable |=> enable_reg == $past(wdata[PINS-1:0]))
    else $error("pin enable write lost");
  AST_CTRL_WRITE: assert property (@(posedge clock) disable iff (rst)
    wr_status |=> (sens_reg == $past(wdata[KPI_BIT_SENS])
      && mask_reg == $past(wdata[KPI_BIT_MASK])))
    else $error("status control write lost");
endmodule : kpi_unit

// ===== bench/kpi_keys.sv
// key model for the keypad pins
module kpi_keys (
  // key state from the bench
  input  wire logic [7:0] press,
  // pin levels
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released key leaves the pin to the pull-up, so it reads high
  assign pins = ~press;
endmodule // kpi_keys

// ===== bench/tb.sv
// self-checking bench for the keypad interrupt unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kpi_pkg::*;
  logic       clock = 0, rst = 1, wr_stb = 0, rd_stb = 0, osc = 0, six = 1, vf = 0;
  logic [7:0] addr = '0, wdata = '0, dir = '0, pu = '0, press = '0, en, v;
  logic [7:0] rdata, pins, pull, fin, rlev;
  logic       irq, wake;
  int         n_errors = 0, checks = 0, k, j;
  kpi_keys u_kpi_keys (.press(press), .pins(pins));
  kpi_unit u_kpi_unit (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .keypad_input_pin(pins),
    .port_direction(dir), .port_pullup_enable(pu), .oscillator_select(osc),
    .port_pin_six_enable(six), .pin_pullup_on(pull), .pin_force_input(fin),
    .pin_read_level(rlev), .vector_fetch(vf), .cpu_irq(irq), .wake_request(wake));
  initial forever #4 clock = ~clock;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, d);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'h1;
    cyc(1);
    wr_stb <= 1'h0;
    cyc(1);
  endtask
  // read data stand only in the cycle after the strobe, so sample 1 ns after the edge that captures them
  task automatic rchk(input logic [7:0] a, e);
    addr   <= a;
    rd_stb <= 1'h1;
    cyc(1);
    rd_stb <= 1'h0;
    #1 chk($sformatf("reg %h", a), rdata, e);
    cyc(1);
  endtask
  function automatic logic [7:0] st(input logic p, m, s);
    return {4'h0, p, 1'h0, m, s};
  endfunction
  initial begin
    void'($urandom(83382));
    cyc(20);
    rst <= 1'h0;
    cyc(1);
    rchk(KPI_ADDR_STATUS, st(0, 0, 0));
    rchk(KPI_ADDR_ENABLE, 8'h00);
    rchk(8'h33, 8'h00);
    en = 8'($urandom);
    wr(KPI_ADDR_STATUS, st(0, 1, 0));
    wr(KPI_ADDR_ENABLE, en);
    wr(KPI_ADDR_STATUS, 8'h06);
    wr(KPI_ADDR_STATUS, 8'h00);
    dir <= 8'($urandom);
    pu  <= 8'($urandom);
    cyc(2);
    rchk(KPI_ADDR_ENABLE, en);
    chk("pullup", pull, pu | en);
    chk("force", fin, en);
    chk("level", rlev, ~dir);
    $display("pin config test done");
    wr(KPI_ADDR_ENABLE, 8'hff);
    k = $urandom_range(7, 0);
    j = (k + 1 + $urandom_range(6, 0)) % 8;
    press <= 8'h01 << k;
    cyc(4);
    chk("irq", irq, 1);
    chk("wake", wake, 1);
    wr(KPI_ADDR_STATUS, 8'h04);
    rchk(KPI_ADDR_STATUS, st(0, 0, 0));
    press <= press | (8'h01 << j);
    cyc(4);
    rchk(KPI_ADDR_STATUS, st(0, 0, 0));
    press <= 8'h00;
    cyc(4);
    press <= 8'h01 << j;
    cyc(4);
    rchk(KPI_ADDR_STATUS, st(1, 0, 0));
    vf <= 1'h1;
    cyc(1);
    vf <= 1'h0;
    cyc(2);
    chk("fetch", irq, 0);
    $display("edge test done");
    press <= 8'h00;
    wr(KPI_ADDR_STATUS, st(0, 1, 0));
    cyc(4);
    press <= 8'h01 << k;
    cyc(4);
    chk("masked", wake, 0);
    rchk(KPI_ADDR_STATUS, st(1, 1, 0));
    wr(KPI_ADDR_STATUS, 8'h05);
    rchk(KPI_ADDR_STATUS, st(1, 0, 1));
    chk("level irq", irq, 1);
    wr(KPI_ADDR_STATUS, 8'h05);
    rchk(KPI_ADDR_STATUS, st(1, 0, 1));
    press <= 8'h00;
    cyc(4);
    rchk(KPI_ADDR_STATUS, st(0, 0, 1));
    press <= 8'h01 << j;
    cyc(4);
    press <= 8'h00;
    cyc(4);
    rchk(KPI_ADDR_STATUS, st(1, 0, 1));
    wr(KPI_ADDR_STATUS, 8'h05);
    rchk(KPI_ADDR_STATUS, st(0, 0, 1));
    press <= 8'h01 << j;
    cyc(4);
    rst <= 1'h1;
    cyc(2);
    rst <= 1'h0;
    cyc(2);
    rchk(KPI_ADDR_STATUS, st(0, 0, 0));
    $display("level and reset test done");
    press <= 8'h00;
    osc   <= 1'h1;
    wr(KPI_ADDR_ENABLE, 8'h40);
    cyc(1);
    chk("six off", fin, 8'h00);
    press <= 8'h40;
    cyc(4);
    chk("six irq", irq, 0);
    press <= 8'h00;
    cyc(4);
    osc   <= 1'h0;
    cyc(2);
    wr(KPI_ADDR_STATUS, 8'h04);
    chk("six idle", irq, 0);
    press <= 8'h40;
    cyc(4);
    chk("six on", irq, 1);
    $display("pin six test done");
    end_of_test();
  end
  initial begin
    #20us;
    n_errors++;
    end_of_test();
  end
endmodule // tb
